// ==== src/fel_core.sv ====
// fault escalation, hard fault preemption and lockup control
// assumes the pipeline reports the running context kind and priority
// and raises at most one fault per cycle; lower priority value wins
module fel_core
  import fel_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // fault from the pipeline
  input  wire fel_fault_t            fault_in,
  // fault configuration
  input  wire fel_cfg_t              cfg,
  // running context
  input  wire fel_kind_t             cur_kind,
  input  wire logic [FEL_PRIO_W-1:0] cur_prio,
  // other exception sources
  input  wire logic                  nmi_req,
  input  wire logic                  dbg_halt_req,
  input  wire logic                  irq_req,
  input  wire logic [FEL_PRIO_W-1:0] irq_prio,
  // log clear strobes
  input  wire fel_clr_t              log_clr,
  // exception entry
  output logic                       take_valid,
  output fel_kind_t                  take_kind,
  output logic                       take_esc,
  // lockup and halt
  output logic                       lockup,
  output logic                       lockup_nmi,
  output logic                       halted,
  // fault logs
  output fel_log_t                   log_q
);

  typedef struct packed {
    fel_state_t st;
    logic       lock_nmi;
    logic       halted;
    logic       take_valid;
    fel_kind_t  take_kind;
    logic       take_esc;
  } fel_core_state_t;

  fel_core_state_t st_reg;
  fel_core_state_t st_next;

  function automatic logic [FEL_PRIO_W-1:0] prio_of(
    input fel_kind_t k, input fel_cfg_t c);
    case (k)
      FEL_MEM:   prio_of = c.mem_prio;
      FEL_BUS:   prio_of = c.bus_prio;
      FEL_USAGE: prio_of = c.usage_prio;
      default:   prio_of = 8'h00;
    endcase
  endfunction : prio_of

  function automatic logic en_of(input fel_kind_t k, input fel_cfg_t c);
    case (k)
      FEL_MEM:   en_of = c.mem_en;
      FEL_BUS:   en_of = c.bus_en;
      FEL_USAGE: en_of = c.usage_en;
      default:   en_of = 1'b0;
    endcase
  endfunction : en_of

  // true when an exception of priority p cannot preempt the context
  function automatic logic blocked(
    input fel_kind_t k, input logic [FEL_PRIO_W-1:0] cp,
    input logic [FEL_PRIO_W-1:0] p);
    case (k)
      FEL_THREAD:         blocked = 1'b0;
      FEL_NMI, FEL_HARD:  blocked = 1'b1;
      default:            blocked = p >= cp;
    endcase
  endfunction : blocked

  logic cfg_fault;
  logic exempt;
  logic escalate;
  logic hard;
  logic nmi_take;
  logic log_valid;

  always_comb begin
    cfg_fault = fault_in.valid && (fault_in.kind == FEL_MEM ||
                fault_in.kind == FEL_BUS || fault_in.kind == FEL_USAGE);
    // entry push for the bus handler keeps the bus fault
    exempt = fault_in.kind == FEL_BUS && fault_in.entry_push;
    escalate = cfg_fault && !exempt &&
      (!en_of(fault_in.kind, cfg) ||
       cur_kind == fault_in.kind ||
       blocked(cur_kind, cur_prio, prio_of(fault_in.kind, cfg)));
    hard = fault_in.valid && (fault_in.kind == FEL_HARD || escalate);
    nmi_take = st_reg.st == FEL_ST_RUN && nmi_req && cur_kind != FEL_NMI;
    log_valid = fault_in.valid && st_reg.st == FEL_ST_RUN && !nmi_take;
  end

  always_comb begin
    st_next = st_reg;
    st_next.take_valid = 1'b0;
    st_next.take_esc = 1'b0;
    case (st_reg.st)
      FEL_ST_LOCK: begin
        if (dbg_halt_req) begin
          st_next.st = FEL_ST_RUN;
          st_next.halted = 1'b1;
        end else if (nmi_req && !st_reg.lock_nmi) begin
          st_next.st = FEL_ST_RUN;
          st_next.take_valid = 1'b1;
          st_next.take_kind = FEL_NMI;
        end
      end
      FEL_ST_RUN: begin
        st_next.halted = st_reg.halted && dbg_halt_req;
        if (nmi_take) begin
          // nmi outranks even a hard fault
          st_next.take_valid = 1'b1;
          st_next.take_kind = FEL_NMI;
        end else if (hard) begin
          if (cur_kind == FEL_NMI || cur_kind == FEL_HARD) begin
            st_next.st = FEL_ST_LOCK;
            st_next.lock_nmi = cur_kind == FEL_NMI;
          end else begin
            st_next.take_valid = 1'b1;
            st_next.take_kind = FEL_HARD;
            st_next.take_esc = escalate;
          end
        end else if (cfg_fault) begin
          st_next.take_valid = 1'b1;
          st_next.take_kind = fault_in.kind;
        end else if (irq_req && !blocked(cur_kind, cur_prio, irq_prio)) begin
          st_next.take_valid = 1'b1;
          st_next.take_kind = FEL_OTHER;
        end
      end
      default: begin
        st_next.st = FEL_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{FEL_ST_RUN, 1'b0, 1'b0, 1'b0, FEL_THREAD, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign take_valid = st_reg.take_valid;
  assign take_kind  = st_reg.take_kind;
  assign take_esc   = st_reg.take_esc;
  assign lockup     = st_reg.st == FEL_ST_LOCK;
  assign lockup_nmi = st_reg.st == FEL_ST_LOCK && st_reg.lock_nmi;
  assign halted     = st_reg.halted;

  fel_fault_log u_log (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .log_valid (log_valid),
    .log_esc   (escalate),
    .log_fault (fault_in),
    .log_clr   (log_clr),
    .log_q     (log_q)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // deciding cycle: not locked and no nmi claiming the cycle
  logic run_free;
  assign run_free = !lockup && !(nmi_req && cur_kind != FEL_NMI);

  same_kind_a: assert property (
    run_free && (fault_in.valid && fault_in.kind == FEL_USAGE &&
    cur_kind == FEL_USAGE)
    |=> take_valid && take_kind == FEL_HARD && take_esc)
    else $error("same kind fault not escalated");

  low_prio_a: assert property (
    run_free && (cfg_fault && !exempt && cur_kind == FEL_OTHER &&
    prio_of(fault_in.kind, cfg) >= cur_prio)
    |=> take_kind == FEL_HARD && take_esc)
    else $error("low priority fault not escalated");

  disabled_a: assert property (
    run_free && (cfg_fault && !exempt && cur_kind == FEL_THREAD &&
    !en_of(fault_in.kind, cfg))
    |=> take_valid && take_kind == FEL_HARD && take_esc)
    else $error("disabled fault not escalated");

  push_exempt_a: assert property (
    run_free && (fault_in.valid && fault_in.kind == FEL_BUS &&
    fault_in.entry_push)
    |=> take_valid && take_kind == FEL_BUS && !take_esc)
    else $error("entry push bus fault escalated");

  hard_wins_a: assert property (
    take_valid && take_kind == FEL_OTHER
    |-> $past(cur_kind) != FEL_HARD && $past(cur_kind) != FEL_NMI)
    else $error("hard fault preempted by interrupt");

  lock_enter_a: assert property (
    run_free && (hard && cur_kind == FEL_HARD)
    |=> lockup && !take_valid)
    else $error("no lockup on hard fault in hard handler");

  lock_hold_a: assert property (
    lockup && !dbg_halt_req && !nmi_req |=> lockup)
    else $error("lockup left without cause");

  nmi_lock_a: assert property (
    lockup_nmi && !dbg_halt_req ##1 !dbg_halt_req |-> lockup_nmi)
    else $error("nmi lockup released without halt");

  lock_cov: cover property (run_free && (hard && cur_kind == FEL_NMI)
    ##1 lockup_nmi);
  esc_cov: cover property (take_valid && take_esc);
  nmi_exit_cov: cover property (lockup && !lockup_nmi && nmi_req
    ##1 take_kind == FEL_NMI);

endmodule : fel_core

// ==== src/fel_fault_log.sv ====
// sticky fault cause logs and captured fault addresses
// assumes log_valid is a one-cycle pulse from the escalation logic
module fel_fault_log
  import fel_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // recorded fault
  input  wire logic       log_valid,
  input  wire logic       log_esc,
  input  wire fel_fault_t log_fault,
  // clear strobes
  input  wire fel_clr_t   log_clr,
  // log contents
  output fel_log_t        log_q
);

  fel_log_t log_reg;
  fel_log_t log_next;

  function automatic logic [FEL_CAUSE_W-1:0] upd(
    input logic [FEL_CAUSE_W-1:0] old,
    input logic [FEL_CAUSE_W-1:0] clr,
    input logic                   set,
    input logic [FEL_CAUSE_W-1:0] bits);
    // a set in the same cycle as its clear wins
    upd = (old & ~clr) | (set ? bits : 8'h00);
  endfunction : upd

  always_comb begin
    logic vm;
    logic vb;
    logic vu;
    logic [FEL_HFS_W-1:0] hset;
    vm = log_valid && log_fault.kind == FEL_MEM;
    vb = log_valid && log_fault.kind == FEL_BUS;
    vu = log_valid && log_fault.kind == FEL_USAGE;
    hset = 2'h0;
    hset[FEL_HFS_ESC] = log_valid && log_esc;
    hset[FEL_HFS_DIRECT] = log_valid && log_fault.kind == FEL_HARD;
    log_next = log_reg;
    log_next.hard_fault_cause_status =
      (log_reg.hard_fault_cause_status & ~log_clr.hard) | hset;
    log_next.memory_protection_fault_cause =
      upd(log_reg.memory_protection_fault_cause, log_clr.mem, vm,
          log_fault.cause);
    log_next.bus_error_cause =
      upd(log_reg.bus_error_cause, log_clr.bus, vb, log_fault.cause);
    log_next.usage_error_cause =
      upd(log_reg.usage_error_cause, log_clr.usage, vu, log_fault.cause);
    if (vm && log_fault.addr_valid) begin
      log_next.memory_protection_fault_address = log_fault.addr;
    end
    if (vb && log_fault.addr_valid) begin
      log_next.bus_error_address = log_fault.addr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      log_reg <= '{FEL_HFS_RST, FEL_CAUSE_RST, FEL_ADDR_RST,
                   FEL_CAUSE_RST, FEL_ADDR_RST, FEL_CAUSE_RST};
    end else begin
      log_reg <= log_next;
    end
  end

  assign log_q = log_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  esc_logged_a: assert property (
    log_valid && log_esc |=> log_q.hard_fault_cause_status[FEL_HFS_ESC])
    else $error("escalation not logged");

  addr_capture_a: assert property (
    log_valid && log_fault.kind == FEL_BUS && log_fault.addr_valid
    |=> log_q.bus_error_address == $past(log_fault.addr))
    else $error("bus fault address not captured");

endmodule : fel_fault_log

// ==== src/fel_pkg.sv ====
// shared types and constants for the fault escalation and lockup unit
// assumes a single core clock and an active-low asynchronous reset
package fel_pkg;

  localparam int FEL_PRIO_W  = 8;
  localparam int FEL_CAUSE_W = 8;
  localparam int FEL_ADDR_W  = 32;
  localparam int FEL_HFS_W   = 2;

  // hard fault cause bit positions
  localparam int FEL_HFS_DIRECT = 0;
  localparam int FEL_HFS_ESC    = 1;

  localparam logic [FEL_CAUSE_W-1:0] FEL_CAUSE_RST = 8'h00;
  localparam logic [FEL_ADDR_W-1:0]  FEL_ADDR_RST  = 32'h0000_0000;
  localparam logic [FEL_HFS_W-1:0]   FEL_HFS_RST   = 2'h0;

  // kind of the running context and of an exception being entered
  typedef enum logic [2:0] {
    FEL_THREAD = 3'h0,
    FEL_NMI    = 3'h1,
    FEL_HARD   = 3'h2,
    FEL_MEM    = 3'h3,
    FEL_BUS    = 3'h4,
    FEL_USAGE  = 3'h5,
    FEL_OTHER  = 3'h6
  } fel_kind_t;

  typedef enum logic [0:0] {
    FEL_ST_RUN  = 1'h0,
    FEL_ST_LOCK = 1'h1
  } fel_state_t;

  // fault raised by the pipeline
  typedef struct packed {
    logic                   valid;
    fel_kind_t              kind;
    logic [FEL_CAUSE_W-1:0] cause;
    logic [FEL_ADDR_W-1:0]  addr;
    logic                   addr_valid;
    logic                   entry_push;
  } fel_fault_t;

  // per-fault priority and handler enable
  typedef struct packed {
    logic [FEL_PRIO_W-1:0] mem_prio;
    logic [FEL_PRIO_W-1:0] bus_prio;
    logic [FEL_PRIO_W-1:0] usage_prio;
    logic                  mem_en;
    logic                  bus_en;
    logic                  usage_en;
  } fel_cfg_t;

  // write-one-to-clear strobes for the logs
  typedef struct packed {
    logic [FEL_HFS_W-1:0]   hard;
    logic [FEL_CAUSE_W-1:0] mem;
    logic [FEL_CAUSE_W-1:0] bus;
    logic [FEL_CAUSE_W-1:0] usage;
  } fel_clr_t;

  typedef struct packed {
    logic [FEL_HFS_W-1:0]   hard_fault_cause_status;
    logic [FEL_CAUSE_W-1:0] memory_protection_fault_cause;
    logic [FEL_ADDR_W-1:0]  memory_protection_fault_address;
    logic [FEL_CAUSE_W-1:0] bus_error_cause;
    logic [FEL_ADDR_W-1:0]  bus_error_address;
    logic [FEL_CAUSE_W-1:0] usage_error_cause;
  } fel_log_t;

endpackage : fel_pkg

// ==== tb/fel_core_tb.sv ====
// self-checking bench for the fault escalation and lockup unit
// assumes the one-cycle answer latency of fel_core
module fel_core_tb
  import fel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk, rst_b, nmi_req, dbg_halt_req, irq_req;
  logic                  ld, take_valid, take_esc, lockup, lockup_nmi;
  logic                  halted;
  logic [FEL_PRIO_W-1:0] irq_prio, cur_prio, ld_prio;
  logic [7:0]            uc, eu;
  logic [3:0]            e;
  logic [3:0]            expq[$];
  fel_fault_t            fault_in;
  fel_cfg_t              cfg;
  fel_clr_t              log_clr;
  fel_kind_t             cur_kind, take_kind, ld_kind;
  fel_log_t              log_q;
  int                    mismatches, checked, seed;

  fel_core fel_core_inst (.core_clk(core_clk), .rst_b(rst_b),
    .fault_in(fault_in), .cfg(cfg), .cur_kind(cur_kind),
    .cur_prio(cur_prio), .nmi_req(nmi_req), .dbg_halt_req(dbg_halt_req),
    .irq_req(irq_req), .irq_prio(irq_prio), .log_clr(log_clr),
    .take_valid(take_valid), .take_kind(take_kind), .take_esc(take_esc),
    .lockup(lockup), .lockup_nmi(lockup_nmi), .halted(halted),
    .log_q(log_q));
  fel_pipe_model fel_pipe_model_inst (.core_clk(core_clk), .rst_b(rst_b),
    .take_valid(take_valid), .take_kind(take_kind), .cfg(cfg), .ld(ld),
    .ld_kind(ld_kind), .ld_prio(ld_prio), .cur_kind(cur_kind),
    .cur_prio(cur_prio));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // one cycle of fault and nmi, noting the entry it should give
  task automatic drv(fel_kind_t k, logic [7:0] c, logic [31:0] a, logic p,
                     logic n, logic t, fel_kind_t ek, logic ee);
    @(negedge core_clk);
    if (t)
      expq.push_back({ee, ek});
    fault_in <= {k != FEL_THREAD, k, c, a, 1'b1, p};
    nmi_req <= n;
    @(negedge core_clk);
    fault_in <= '0;
    nmi_req <= 1'b0;
  endtask : drv

  task automatic ctx(fel_kind_t k, logic [7:0] p);
    @(negedge core_clk);
    ld <= 1'b1;
    ld_kind <= k;
    ld_prio <= p;
    @(negedge core_clk);
    ld <= 1'b0;
  endtask : ctx

  // takes the oldest note for every entry seen
  always @(negedge core_clk) begin
    if (rst_b && take_valid === 1'b1) begin
      if (expq.size() == 0)
        check("unexpected take", 32'h1, 32'h0);
      else begin
        e = expq.pop_front();
        check("take_kind", take_kind, e[2:0]);
        check("take_esc", take_esc, e[3]);
      end
    end
  end

  initial begin
    seed = 99;
    rst_b = 1'b0;
    fault_in = '0;
    nmi_req = 1'b0;
    dbg_halt_req = 1'b0;
    irq_req = 1'b0;
    irq_prio = 8'h00;
    ld = 1'b0;
    ld_kind = FEL_THREAD;
    ld_prio = 8'h00;
    log_clr = '0;
    eu = 8'h00;
    cfg = {8'h04, 8'h04, 8'h06, 3'h7};
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    check("lockup", lockup, 1'b0);
    check("hard status", log_q.hard_fault_cause_status, 2'h0);
    repeat (4) begin
      uc = 8'($random(seed));
      eu = eu | uc;
      drv(FEL_USAGE, uc, 32'h0, 1'b0, 1'b0, 1'b1, FEL_USAGE, 1'b0);
      ctx(FEL_THREAD, 8'hff);
    end
    check("usage cause", log_q.usage_error_cause, eu);
    @(negedge core_clk);
    log_clr.usage <= 8'hff;
    @(negedge core_clk);
    log_clr <= '0;
    check("usage clear", log_q.usage_error_cause, 8'h00);
    $display("test logs done");
    drv(FEL_USAGE, 8'h01, 32'h0, 1'b0, 1'b0, 1'b1, FEL_USAGE, 1'b0);
    drv(FEL_USAGE, 8'h02, 32'h0, 1'b0, 1'b0, 1'b1, FEL_HARD, 1'b1);
    check("hard esc", log_q.hard_fault_cause_status, 2'h2);
    @(negedge core_clk);
    irq_req <= 1'b1;
    drv(FEL_THREAD, 8'h00, 32'h0, 1'b0, 1'b0, 1'b0, FEL_THREAD, 1'b0);
    irq_req <= 1'b0;
    drv(FEL_HARD, 8'h00, 32'h0, 1'b0, 1'b0, 1'b0, FEL_THREAD, 1'b0);
    check("lockup", lockup, 1'b1);
    check("lockup_nmi", lockup_nmi, 1'b0);
    check("hard direct", log_q.hard_fault_cause_status, 2'h3);
    drv(FEL_USAGE, 8'h04, 32'h0, 1'b0, 1'b0, 1'b0, FEL_THREAD, 1'b0);
    drv(FEL_THREAD, 8'h00, 32'h0, 1'b0, 1'b1, 1'b1, FEL_NMI, 1'b0);
    check("nmi release", lockup, 1'b0);
    drv(FEL_HARD, 8'h00, 32'h0, 1'b0, 1'b0, 1'b0, FEL_THREAD, 1'b0);
    check("lockup_nmi", lockup_nmi, 1'b1);
    drv(FEL_THREAD, 8'h00, 32'h0, 1'b0, 1'b1, 1'b0, FEL_THREAD, 1'b0);
    check("nmi ignored", lockup, 1'b1);
    @(negedge core_clk);
    dbg_halt_req <= 1'b1;
    @(negedge core_clk);
    check("halt release", lockup, 1'b0);
    check("halted", halted, 1'b1);
    dbg_halt_req <= 1'b0;
    $display("test lockup done");
    ctx(FEL_MEM, 8'h04);
    check("halted clear", halted, 1'b0);
    drv(FEL_BUS, 8'h01, 32'h1000, 1'b0, 1'b0, 1'b1, FEL_HARD, 1'b1);
    ctx(FEL_MEM, 8'h04);
    cfg.bus_prio <= 8'h02;
    drv(FEL_BUS, 8'h02, 32'h2468, 1'b0, 1'b0, 1'b1, FEL_BUS, 1'b0);
    check("bus addr", log_q.bus_error_address, 32'h2468);
    ctx(FEL_OTHER, 8'h03);
    drv(FEL_MEM, 8'h08, 32'h3abc, 1'b0, 1'b0, 1'b1, FEL_HARD, 1'b1);
    check("mem addr", log_q.memory_protection_fault_address, 32'h3abc);
    ctx(FEL_THREAD, 8'hff);
    cfg.mem_en <= 1'b0;
    drv(FEL_MEM, 8'h01, 32'h0, 1'b0, 1'b0, 1'b1, FEL_HARD, 1'b1);
    ctx(FEL_BUS, 8'h02);
    cfg.bus_en <= 1'b0;
    drv(FEL_BUS, 8'h04, 32'h5, 1'b1, 1'b0, 1'b1, FEL_BUS, 1'b0);
    // interrupt above the running bus handler is entered
    @(negedge core_clk);
    expq.push_back({1'b0, FEL_OTHER});
    irq_req <= 1'b1;
    irq_prio <= 8'h01;
    @(negedge core_clk);
    irq_req <= 1'b0;
    check("bus cause", log_q.bus_error_cause, 8'h07);
    check("mem cause", log_q.memory_protection_fault_cause, 8'h09);
    log_clr <= '1;
    @(negedge core_clk);
    log_clr <= '0;
    check("hard clear", log_q.hard_fault_cause_status, 2'h0);
    check("bus clear", log_q.bus_error_cause, 8'h00);
    $display("test escalation done");
    repeat (10) begin
      if (expq.size() != 0)
        @(negedge core_clk);
    end
    check("missing takes", expq.size(), 32'h0);
    stop_test();
  end
endmodule : fel_core_tb

// ==== tb/fel_pipe_model.sv ====
// partner model: running context kept by the pipeline
// assumes take pulses from fel_core; the bench may load a context
module fel_pipe_model
  import fel_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // exception entry
  input  wire logic                  take_valid,
  input  wire fel_kind_t             take_kind,
  input  wire fel_cfg_t              cfg,
  // context load
  input  wire logic                  ld,
  input  wire fel_kind_t             ld_kind,
  input  wire logic [FEL_PRIO_W-1:0] ld_prio,
  // running context
  output fel_kind_t                  cur_kind,
  output logic [FEL_PRIO_W-1:0]      cur_prio
);
  timeunit 1ns;
  timeprecision 1ns;
  // changed off the sampling edge, like the rest of the stimulus
  always @(negedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_kind <= FEL_THREAD;
      cur_prio <= 8'hff;
    end else if (ld) begin
      cur_kind <= ld_kind;
      cur_prio <= ld_prio;
    end else if (take_valid) begin
      cur_kind <= take_kind;
      case (take_kind)
        FEL_MEM:   cur_prio <= cfg.mem_prio;
        FEL_BUS:   cur_prio <= cfg.bus_prio;
        FEL_USAGE: cur_prio <= cfg.usage_prio;
        default:   cur_prio <= 8'h00;
      endcase
    end
  end
endmodule : fel_pipe_model
